// File: hw/target_remap_pkg.sv
// Purpose: constants for the remote target physical address remap table
// Assumes: 8-bit register access from the local register port
// Notes:   one table copy per receive port
package target_remap_pkg;
    localparam int unsigned NUM_PORTS      = 2;
    localparam int unsigned PORT_SEL_W     = 1;
    localparam int unsigned FIRST_SLOT     = 2;
    localparam int unsigned NUM_SLOTS      = 6;
    localparam int unsigned ADDR_W         = 7;
    localparam logic [7:0]  PORT_SEL_ADDR  = 8'h4C;
    localparam logic [7:0]  SLOT2_ADDR     = 8'h5F;
    localparam logic [7:0]  SLOT3_ADDR     = 8'h60;
    localparam logic [7:0]  SLOT4_ADDR     = 8'h61;
    localparam logic [7:0]  SLOT5_ADDR     = 8'h62;
    localparam logic [7:0]  SLOT6_ADDR     = 8'h63;
    localparam logic [7:0]  SLOT7_ADDR     = 8'h64;
    localparam int unsigned PHYS_MSB       = 7;
    localparam int unsigned PHYS_LSB       = 1;
    localparam logic [6:0]  PHYS_RESET     = 7'h00;
    localparam logic [6:0]  ALIAS_DISABLED = 7'h00;
    localparam logic [7:0]  PORT_SEL_RESET = 8'h01;
    localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
endpackage

// File: hw/remote_i2c_target_address_remap.sv
// Purpose: per-port table of remote target physical addresses, slots 2 to 7,
//          and the alias to physical address translation for pass-through
// Assumes: register port and lookup are synchronous to clock
// Notes:   alias values come from outside this block
//          equal aliases on several slots: the lowest slot is forwarded
//          a port selector with neither port bit set reaches the port 0 copy
`timescale 1ns/1ns
module remote_i2c_target_address_remap (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [1:0]  lookup_port,
    input  wire logic        lookup_valid,
    input  wire logic [6:0]  lookup_addr,
    input  wire logic [41:0] alias_slot_match_addr,
    output logic             fwd_valid,
    output logic      [6:0]  fwd_addr,
    output logic      [2:0]  fwd_slot
);

    ////////////////////////////////////////////////////////////////////////////
    typedef logic [target_remap_pkg::ADDR_W-1:0]        phys_type;
    typedef logic [target_remap_pkg::PORT_SEL_W-1:0]    port_type;
    typedef phys_type [target_remap_pkg::NUM_SLOTS-1:0] row_type;

    // outcome of one alias lookup against one port's copy of the table
    typedef struct packed {
        logic       valid;
        phys_type   addr;
        logic [2:0] slot;
    } match_type;

    localparam logic [2:0] NO_SLOT = 3'h7;

    typedef struct packed {
        phys_type [target_remap_pkg::NUM_PORTS-1:0][target_remap_pkg::NUM_SLOTS-1:0] phys;
        logic [7:0] rx_port_selector;
        logic [7:0] rdata;
        logic       fwd_valid;
        logic [6:0] fwd_addr;
        logic [2:0] fwd_slot;
    } state_type;

    state_type state_q;
    state_type state_d;

    // slot index 0..5 for addresses 0x5F..0x64, 7 when unmapped
    function automatic logic [2:0] slot_of(input logic [7:0] addr);
        logic [2:0] idx;
        idx = 3'h7;
        if (addr == target_remap_pkg::SLOT2_ADDR) begin
            idx = 3'h0;
        end else if (addr == target_remap_pkg::SLOT3_ADDR) begin
            idx = 3'h1;
        end else if (addr == target_remap_pkg::SLOT4_ADDR) begin
            idx = 3'h2;
        end else if (addr == target_remap_pkg::SLOT5_ADDR) begin
            idx = 3'h3;
        end else if (addr == target_remap_pkg::SLOT6_ADDR) begin
            idx = 3'h4;
        end else if (addr == target_remap_pkg::SLOT7_ADDR) begin
            idx = 3'h5;
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // copy reached by the register port: bit 0 wins, then bit 1, else port 0
    function automatic port_type port_of(input logic [7:0] selector);
        port_type idx;
        idx = port_type'(0);
        if (selector[0]) begin
            idx = port_type'(0);
        end else if (selector[1]) begin
            idx = port_type'(1);
        end
        return idx;
    endfunction

    // decode of the port selector address, shared by writes and reads
    function automatic logic hits_port_sel(input logic [7:0] addr);
        logic hit;
        hit = (addr == target_remap_pkg::PORT_SEL_ADDR);
        return hit;
    endfunction

    // slot byte as read back: address in bits 7:1, reserved bit 0 always zero
    function automatic logic [7:0] slot_byte(input phys_type phys);
        logic [7:0] value;
        value = 8'h00;
        value[target_remap_pkg::PHYS_MSB:target_remap_pkg::PHYS_LSB] = phys;
        value[0] = 1'b0;
        return value;
    endfunction

    // address field of a written slot byte; bit 0 is dropped
    function automatic phys_type slot_field(input logic [7:0] value);
        phys_type phys;
        phys = value[target_remap_pkg::PHYS_MSB:target_remap_pkg::PHYS_LSB];
        return phys;
    endfunction

    // alias of table entry n, slot 2 in the lowest seven bits
    function automatic phys_type alias_of(
        input logic [41:0] aliases,
        input int          n
    );
        phys_type value;
        value = aliases[n * target_remap_pkg::ADDR_W +: target_remap_pkg::ADDR_W];
        return value;
    endfunction

    // a zero alias switches its slot off, so it can never claim a transaction
    function automatic logic alias_hit(
        input phys_type alias_value,
        input phys_type addr
    );
        logic hit;
        hit = 1'b0;
        if (alias_value != target_remap_pkg::ALIAS_DISABLED) begin
            hit = (alias_value == addr);
        end
        return hit;
    endfunction

    // scan from the highest slot down, so the lowest matching slot is kept
    function automatic match_type find_match(
        input logic [41:0] aliases,
        input row_type     row,
        input phys_type    addr
    );
        match_type result;
        phys_type  alias_value;
        result = '0;
        for (int i = target_remap_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
            alias_value = alias_of(aliases, i);
            if (alias_hit(alias_value, addr)) begin
                result.valid = 1'b1;
                result.addr  = row[i];
                result.slot  = 3'(i + target_remap_pkg::FIRST_SLOT);
            end
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [2:0] slot_idx;
    port_type   port_idx;
    logic       lookup_ok;
    match_type  found;

    always_comb begin
        state_d   = state_q;
        slot_idx  = slot_of(reg_addr);
        port_idx  = port_of(state_q.rx_port_selector);
        lookup_ok = 1'b0;
        found     = '0;

        // writes reach the selector or one slot of the selected port's copy
        if (reg_write) begin
            if (hits_port_sel(reg_addr)) begin
                state_d.rx_port_selector = reg_wdata;
            end else if (slot_idx != NO_SLOT) begin
                state_d.phys[port_idx][slot_idx] = slot_field(reg_wdata);
            end
        end

        // read data stands for one cycle and returns to zero
        state_d.rdata = target_remap_pkg::UNMAPPED_READ;
        if (reg_read) begin
            if (hits_port_sel(reg_addr)) begin
                state_d.rdata = state_q.rx_port_selector;
            end else if (slot_idx != NO_SLOT) begin
                state_d.rdata = slot_byte(state_q.phys[port_idx][slot_idx]);
            end
        end

        // lookup sees the table as it stood before a write on the same edge
        lookup_ok = lookup_valid && (lookup_port < 2'(target_remap_pkg::NUM_PORTS));
        if (lookup_ok) begin
            found = find_match(alias_slot_match_addr,
                               state_q.phys[port_type'(lookup_port)],
                               lookup_addr);
        end
        state_d.fwd_valid = found.valid;
        state_d.fwd_addr  = found.addr;
        state_d.fwd_slot  = found.slot;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int p = 0; p < target_remap_pkg::NUM_PORTS; p++) begin
                for (int s = 0; s < target_remap_pkg::NUM_SLOTS; s++) begin
                    state_q.phys[p][s] <= target_remap_pkg::PHYS_RESET;
                end
            end
            state_q.rx_port_selector <= target_remap_pkg::PORT_SEL_RESET;
            state_q.rdata            <= 8'h00;
            state_q.fwd_valid        <= 1'b0;
            state_q.fwd_addr         <= 7'h00;
            state_q.fwd_slot         <= 3'h0;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign fwd_valid = state_q.fwd_valid;
    assign fwd_addr  = state_q.fwd_addr;
    assign fwd_slot  = state_q.fwd_slot;

endmodule

// File: testbench/remap_sva.sv
// Purpose: port checks of the remap table. Assumes: one clock. Notes: bound from the bench.
`timescale 1ns/1ns
module remap_sva (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic [1:0]  lookup_port,
    input wire logic        lookup_valid,
    input wire logic [6:0]  lookup_addr,
    input wire logic [41:0] alias_slot_match_addr,
    input wire logic        fwd_valid,
    input wire logic [6:0]  fwd_addr,
    input wire logic [2:0]  fwd_slot
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    rdata_idle_a: assert property
        (!reg_read |=> reg_rdata == 8'h00) else $error("read data not idle");
    unmapped_zero_a: assert property
        (reg_read && !(reg_addr inside {8'h4C, [8'h5F:8'h64]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    bit0_zero_a: assert property
        (reg_read && reg_addr inside {[8'h5F:8'h64]} |=> !reg_rdata[0]) else $error("bit 0 set");
    slot2_match_a: assert property
        (lookup_valid && !lookup_port[1] && lookup_addr != 7'h00 &&
         lookup_addr == alias_slot_match_addr[6:0] |=> fwd_valid && fwd_slot == 3'h2)
        else $error("slot 2 alias missed");
    zero_alias_a: assert property
        (lookup_valid && lookup_addr == 7'h00 |=> !fwd_valid) else $error("zero alias forwarded");
    bad_port_a: assert property
        (lookup_valid && lookup_port[1] |=> !fwd_valid) else $error("bad port forwarded");
    fwd_cause_a: assert property
        (fwd_valid |-> $past(lookup_valid) && fwd_slot inside {[3'h2:3'h7]})
        else $error("forward without lookup");
    fwd_idle_a: assert property
        (!fwd_valid |-> fwd_addr == 7'h00 && fwd_slot == 3'h0) else $error("idle forward not zero");
endmodule

// File: testbench/alias_model.sv
// Purpose: alias side model. Assumes: static aliases. Notes: slot 7 left disabled.
`timescale 1ns/1ns
module alias_model (output logic [41:0] aliases);
    // slot 7 alias is zero, so that target stays unreachable
    assign aliases = {7'h00, 7'h35, 7'h34, 7'h33, 7'h32, 7'h31};
endmodule

// File: testbench/tb_remote_i2c_target_address_remap.sv
// Purpose: bench of the remap table. Assumes: 4 ns clock. Notes: aliases from alias_model.
`timescale 1ns/1ns
module tb_remote_i2c_target_address_remap;
    logic        clock = 0, reset = 1, reg_write = 0, reg_read = 0, lookup_valid = 0, fwd_valid;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0]  lookup_port = 2'h0;
    logic [6:0]  lookup_addr = 7'h00, fwd_addr;
    logic [2:0]  fwd_slot;
    logic [41:0] alias_slot_match_addr;
    int          errors = 0, n_checks = 0;
    initial forever #2 clock = ~clock;
    alias_model u_alias (.aliases(alias_slot_match_addr));
    remote_i2c_target_address_remap u_dut (
        .clock                 (clock),
        .reset                 (reset),
        .reg_write             (reg_write),
        .reg_read              (reg_read),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_rdata             (reg_rdata),
        .lookup_port           (lookup_port),
        .lookup_valid          (lookup_valid),
        .lookup_addr           (lookup_addr),
        .alias_slot_match_addr (alias_slot_match_addr),
        .fwd_valid             (fwd_valid),
        .fwd_addr              (fwd_addr),
        .fwd_slot              (fwd_slot)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task ck(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) #1 {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clock) #1 reg_write = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock) #1 {reg_read, reg_addr} = {1'b1, a};
        @(posedge clock) #1 reg_read = 0;
        ck({3'h0, reg_rdata}, {3'h0, e});
    endtask
    task lk(input logic [1:0] p, input logic [6:0] a, input logic [10:0] e);
        @(posedge clock) #1 {lookup_valid, lookup_port, lookup_addr} = {1'b1, p, a};
        @(posedge clock) #1 lookup_valid = 0;
        ck({fwd_valid, fwd_slot, fwd_addr}, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        for (int i = 0; i < 6; i++) rd(8'(8'h5F + i), 8'h00);
        rd(8'h4C, 8'h01);
    endtask
    task t_ports;
        for (int p = 0; p < 2; p++) begin
            wr(8'h4C, 8'(p + 1));
            for (int i = 0; i < 6; i++) wr(8'(8'h5F + i), 8'(8'h81 + 32 * p + 2 * i));
        end
        for (int i = 0; i < 6; i++) rd(8'(8'h5F + i), 8'(8'hA0 + 2 * i));
        wr(8'h4C, 8'h01);
        rd(8'h60, 8'h82);
        wr(8'h4C, 8'h03);
        rd(8'h60, 8'h82);
        wr(8'h4C, 8'h00);
        rd(8'h4C, 8'h00);
        rd(8'h60, 8'h82);
        wr(8'h4C, 8'h01);
        rd(8'h10, 8'h00);
    endtask
    task t_lookup;
        for (int i = 0; i < 5; i++) begin
            lk(2'h0, 7'(7'h31 + i), {1'b1, 3'(i + 2), 7'(7'h40 + i)});
        end
        lk(2'h1, 7'h33, {4'hC, 7'h52});
        lk(2'h0, 7'h00, 11'h000);
        lk(2'h2, 7'h31, 11'h000);
        lk(2'h0, 7'h7F, 11'h000);
    endtask
    task t_rereset;
        @(posedge clock) #1 reset = 1;
        repeat (2) @(posedge clock);
        #1 reset = 0;
        t_reset;
        lk(2'h0, 7'h31, {4'hA, 7'h00});
        wr(8'h4C, 8'h02);
        rd(8'h5F, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        #1 reset = 0;
        t_reset;
        t_ports;
        t_lookup;
        t_rereset;
        end_of_test;
    end
    initial begin
        #2000;
        errors++;
        end_of_test;
    end
endmodule
bind remote_i2c_target_address_remap remap_sva u_sva (
    .clock                 (clock),
    .reset                 (reset),
    .reg_write             (reg_write),
    .reg_read              (reg_read),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .lookup_port           (lookup_port),
    .lookup_valid          (lookup_valid),
    .lookup_addr           (lookup_addr),
    .alias_slot_match_addr (alias_slot_match_addr),
    .fwd_valid             (fwd_valid),
    .fwd_addr              (fwd_addr),
    .fwd_slot              (fwd_slot)
);
